/* File: core/dead_time_phase.sv */
// One complementary phase pair with dead-time insertion.
// Assumes a timer tick pulse in the same clock domain and a synchronous reset.
`timescale 1ns/100ps
module dead_time_phase #(
    parameter logic [7:0] DEAD = motor_pwm_pkg::DEAD_W
) (
    input  wire logic clk_in,
    input  wire logic rstn_in,
    input  wire logic tick_in,
    input  wire logic run_in,
    input  wire logic level_in,
    output logic      hi_out,
    output logic      lo_out
);

    logic       lvl_q, lvl_d;
    logic [7:0] dt_q,  dt_d;
    logic       hi_q,  hi_d;
    logic       lo_q,  lo_d;

    always_comb begin
        lvl_d = lvl_q;
        dt_d  = dt_q;
        hi_d  = 1'b0;
        lo_d  = 1'b0;
        if (!run_in) begin
            // A fresh start also waits one dead time before any side turns on
            dt_d  = DEAD;
            lvl_d = level_in;
        end else if (level_in != lvl_q) begin
            lvl_d = level_in;
            dt_d  = DEAD;
        end else if (dt_q != 8'h00) begin
            if (tick_in) begin
                dt_d = dt_q - 8'h01;
            end
        end else begin
            hi_d = lvl_q;
            lo_d = !lvl_q;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            lvl_q <= 1'b0;
            dt_q  <= DEAD;
            hi_q  <= 1'b0;
            lo_q  <= 1'b0;
        end else begin
            lvl_q <= lvl_d;
            dt_q  <= dt_d;
            hi_q  <= hi_d;
            lo_q  <= lo_d;
        end
    end

    assign hi_out = hi_q;
    assign lo_out = lo_q;

endmodule // dead_time_phase

/* File: core/dual_motor_pwm_adc_protect.sv */
// Two three-phase complementary PWM generators with A/D trigger timing,
// output-disable protection, low-voltage reset and reset cause capture.
// Assumes all inputs synchronous to clk_in; the A/D units and power stage are outside.
`timescale 1ns/100ps

// Function
// - Outputs idle after reset until start button; stop button stops output.
// - Carrier 8 kHz, 2 us dead time between phase and complement switching.
// - Motor 1 halves asymmetric, 6 us offset between left and right.
// - Motor 2 three phases, symmetric left and right halves.
// - Three converter units scan groups A and B on separate triggers, group C continuously while running.
// - Unit 0 group A double trigger, results to two data registers.
// - Motor 1 shunt samples triggered at counts 600 and 4500; position tops out at 1000, so the 4500 trigger never fires.
// - Unit 1 group A samples three channels at motor 2 trough.
// - Fault input or comparator detection puts all PWM pins high impedance.
// - Supply below 2.51 V causes a device reset.
// - Cause of the latest reset is kept readable.
// - Period count is timer clock over carrier; half is the peak.
// - Duties stepped through 360-entry table; motor 1 uses a second table.
// - Each phase has a complementary output; six pins per motor.
// - One output per motor toggles every carrier cycle.
// - Conversion status pins and frame sync pulse on start requests.
module dual_motor_pwm_adc_protect #(
    parameter logic [15:0] TRIG_1 = motor_pwm_pkg::ADC_T1,
    parameter logic [15:0] TRIG_2 = motor_pwm_pkg::ADC_T2
) (
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    input  wire logic       start_button_in,
    input  wire logic       stop_button_in,
    input  wire logic       fault_input_0_n_in,
    input  wire logic       fault_input_4_n_in,
    input  wire logic       comparator_in,
    input  wire logic       supply_low_in,
    input  wire logic [2:0] adc_done_in,
    output logic      [2:0] motor1_phase_out,
    output logic      [2:0] motor1_phase_n_out,
    output logic      [2:0] motor2_phase_out,
    output logic      [2:0] motor2_phase_n_out,
    output logic            pwm_oe_out,
    output logic      [2:0] adc_trig_a_out,
    output logic      [2:0] adc_trig_b_out,
    output logic      [2:0] adc_scan_c_out,
    output logic            adc0_result_sel_out,
    output logic            conv_status_out_0,
    output logic            conv_status_out_1,
    output logic            conv_frame_sync_0,
    output logic            conv_frame_sync_1,
    output logic            cycle_toggle_out_1,
    output logic            cycle_toggle_out_2,
    output logic            comparator_out,
    output logic      [1:0] reset_cause_out,
    output logic            running_out
);

    // Duty for a table slot: a smooth triangle between 1/8 and 7/8 of peak.
    // Computed instead of stored, so the table costs no memory.
    function automatic logic [15:0] duty_of(input logic [8:0] idx);
        logic [8:0]  tri_v;
        logic [31:0] prod;
        tri_v = (idx < motor_pwm_pkg::TABLE_HALF) ? idx : 9'(9'(motor_pwm_pkg::TABLE_LEN) - idx);
        prod  = 32'(tri_v) * 32'(motor_pwm_pkg::PEAK_W - (motor_pwm_pkg::PEAK_W >> 2));
        duty_of = 16'(motor_pwm_pkg::PEAK_W >> 3) + 16'(prod / 32'(motor_pwm_pkg::TABLE_HALF));
    endfunction

    function automatic logic [8:0] idx_add(input logic [8:0] a, input logic [8:0] b);
        logic [9:0] s;
        s = 10'(a) + 10'(b);
        idx_add = (s > 10'(motor_pwm_pkg::TABLE_LAST)) ? 9'(s - 10'(motor_pwm_pkg::TABLE_LEN))
                                                       : 9'(s);
    endfunction

    logic sys_rst_n;
    assign sys_rst_n = rstn_in && !supply_low_in;

    // Reset cause: written during a reset, never cleared by one
    logic [1:0] cause_q, cause_d;
    always_comb begin
        cause_d = cause_q;
        if (!rstn_in) begin
            cause_d = 2'h0;
            cause_d[motor_pwm_pkg::RC_PIN_BIT] = 1'b1;
        end else if (supply_low_in) begin
            cause_d = 2'h0;
            cause_d[motor_pwm_pkg::RC_LVD_BIT] = 1'b1;
        end
    end
    always_ff @(posedge clk_in) begin
        cause_q <= cause_d;
    end

    // Timer tick generator at TIMER_HZ
    logic [5:0] acc_q, acc_d;
    logic       tick_q, tick_d;
    always_comb begin
        acc_d  = acc_q + motor_pwm_pkg::TICK_STEP;
        tick_d = 1'b0;
        if (acc_d >= motor_pwm_pkg::TICK_MOD) begin
            acc_d  = acc_d - motor_pwm_pkg::TICK_MOD;
            tick_d = 1'b1;
        end
    end

    // Start / stop and protection
    motor_pwm_pkg::run_state_t st_q, st_d;
    logic hiz_q, hiz_d;
    logic f0_q, f4_q;
    logic oe_q, oe_d;
    logic cmp_q;
    always_comb begin
        st_d = st_q;
        case (st_q)
            motor_pwm_pkg::ST_IDLE: if (start_button_in && !stop_button_in) begin
                st_d = motor_pwm_pkg::ST_RUN;
            end
            motor_pwm_pkg::ST_RUN: if (stop_button_in) begin
                st_d = motor_pwm_pkg::ST_IDLE;
            end
            default: st_d = motor_pwm_pkg::ST_IDLE;
        endcase
        hiz_d = hiz_q;
        if (start_button_in && fault_input_0_n_in && fault_input_4_n_in && !comparator_in) begin
            hiz_d = 1'b0;
        end
        // Set wins over the release by the start button
        if ((f0_q && !fault_input_0_n_in) || (f4_q && !fault_input_4_n_in) || comparator_in) begin
            hiz_d = 1'b1;
        end
        oe_d = !hiz_d;
    end

    logic run;
    assign run = (st_q == motor_pwm_pkg::ST_RUN);

    // Up/down carrier counters, index 0 is motor 1, index 1 is motor 2
    logic [15:0] cnt_q    [2];
    logic [15:0] cnt_d    [2];
    logic [1:0]  up_q, up_d;
    logic [1:0]  peak_q, peak_d;
    logic [1:0]  trough_q, trough_d;
    logic [1:0]  tgl_q, tgl_d;
    logic        chg_q;
    always_comb begin
        for (int m = 0; m < 2; m++) begin
            cnt_d[m]    = cnt_q[m];
            up_d[m]     = up_q[m];
            peak_d[m]   = 1'b0;
            trough_d[m] = 1'b0;
            tgl_d[m]    = tgl_q[m];
            if (!run) begin
                cnt_d[m] = 16'h0000;
                up_d[m]  = 1'b1;
            end else if (tick_q) begin
                if (up_q[m]) begin
                    if (cnt_q[m] == motor_pwm_pkg::PEAK_W) begin
                        up_d[m]   = 1'b0;
                        cnt_d[m]  = cnt_q[m] - 16'h0001;
                        peak_d[m] = 1'b1;
                    end else begin
                        cnt_d[m] = cnt_q[m] + 16'h0001;
                    end
                end else if (cnt_q[m] == 16'h0000) begin
                    up_d[m]     = 1'b1;
                    cnt_d[m]    = 16'h0001;
                    trough_d[m] = 1'b1;
                    tgl_d[m]    = !tgl_q[m];
                end else begin
                    cnt_d[m] = cnt_q[m] - 16'h0001;
                end
            end
        end
    end

    // Compare values, reloaded at each trough from the duty table
    logic [8:0]  idx_q [2];
    logic [8:0]  idx_d [2];
    logic [15:0] cup_q [2][3];
    logic [15:0] cup_d [2][3];
    logic [15:0] cdn_q [2][3];
    logic [15:0] cdn_d [2][3];
    logic [2:0]  lvl   [2];
    always_comb begin
        for (int m = 0; m < 2; m++) begin
            idx_d[m] = idx_q[m];
            if (!run) begin
                idx_d[m] = 9'h000;
            end else if (trough_q[m]) begin
                idx_d[m] = idx_add(idx_q[m], 9'h001);
            end
            for (int p = 0; p < 3; p++) begin
                logic [15:0] base;
                logic [16:0] late;
                base = duty_of(idx_add(idx_q[m], 9'(PHASE_OF(p))));
                late = 17'(base) + 17'(motor_pwm_pkg::OFFSET_W);
                cup_d[m][p] = cup_q[m][p];
                cdn_d[m][p] = cdn_q[m][p];
                if (trough_q[m] || !run) begin
                    cup_d[m][p] = base;
                    if (m == 0) begin
                        // Second table shifts the falling half by the offset
                        cdn_d[m][p] = (late > 17'(motor_pwm_pkg::PEAK_W))
                                      ? motor_pwm_pkg::PEAK_W : 16'(late);
                    end else begin
                        cdn_d[m][p] = base;
                    end
                end
                lvl[m][p] = up_q[m] ? (cnt_q[m] >= cup_q[m][p]) : (cnt_q[m] >= cdn_q[m][p]);
            end
        end
    end

    function automatic int PHASE_OF(input int p);
        PHASE_OF = p * int'(motor_pwm_pkg::PHASE_SHIFT);
    endfunction

    // A/D trigger timing
    logic [15:0] pos1;
    logic        hit1, hit2;
    logic [2:0]  ta_q, ta_d, tb_q, tb_d, sc_q, sc_d, busy_q, busy_d;
    logic        sel_q, sel_d, fs0_q, fs0_d, fs1_q, fs1_d;
    always_comb begin
        // Position within the whole period, rising then falling half
        pos1 = up_q[0] ? cnt_q[0] : (motor_pwm_pkg::CARRIER_W - cnt_q[0]);
        hit1 = run && chg_q && (pos1 == TRIG_1);
        hit2 = run && chg_q && (pos1 == TRIG_2);
        ta_d[0] = hit1 || hit2;
        ta_d[1] = trough_q[1];
        ta_d[2] = peak_q[0];
        tb_d[0] = peak_q[0];
        tb_d[1] = peak_q[1];
        tb_d[2] = peak_q[1];
        sc_d    = {3{run}};
        sel_d   = sel_q;
        if (hit1) begin
            sel_d = 1'b0;
        end else if (hit2) begin
            sel_d = 1'b1;
        end
        fs0_d = hit2;
        fs1_d = trough_q[1];
        for (int u = 0; u < 3; u++) begin
            busy_d[u] = busy_q[u];
            if (adc_done_in[u]) begin
                busy_d[u] = 1'b0;
            end
            if (ta_d[u] || tb_d[u]) begin
                busy_d[u] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!sys_rst_n) begin
            acc_q    <= 6'h00;
            tick_q   <= 1'b0;
            chg_q    <= 1'b0;
            st_q     <= motor_pwm_pkg::ST_IDLE;
            hiz_q    <= 1'b0;
            oe_q     <= 1'b1;
            f0_q     <= 1'b1;
            f4_q     <= 1'b1;
            cmp_q    <= 1'b0;
            up_q     <= 2'h3;
            peak_q   <= 2'h0;
            trough_q <= 2'h0;
            tgl_q    <= 2'h0;
            ta_q     <= 3'h0;
            tb_q     <= 3'h0;
            sc_q     <= 3'h0;
            busy_q   <= 3'h0;
            sel_q    <= 1'b0;
            fs0_q    <= 1'b0;
            fs1_q    <= 1'b0;
            for (int m = 0; m < 2; m++) begin
                cnt_q[m] <= 16'h0000;
                idx_q[m] <= 9'h000;
                for (int p = 0; p < 3; p++) begin
                    cup_q[m][p] <= motor_pwm_pkg::PEAK_W;
                    cdn_q[m][p] <= motor_pwm_pkg::PEAK_W;
                end
            end
        end else begin
            acc_q    <= acc_d;
            tick_q   <= tick_d;
            chg_q    <= tick_q;
            st_q     <= st_d;
            hiz_q    <= hiz_d;
            oe_q     <= oe_d;
            f0_q     <= fault_input_0_n_in;
            f4_q     <= fault_input_4_n_in;
            cmp_q    <= comparator_in;
            up_q     <= up_d;
            peak_q   <= peak_d;
            trough_q <= trough_d;
            tgl_q    <= tgl_d;
            ta_q     <= ta_d;
            tb_q     <= tb_d;
            sc_q     <= sc_d;
            busy_q   <= busy_d;
            sel_q    <= sel_d;
            fs0_q    <= fs0_d;
            fs1_q    <= fs1_d;
            cnt_q    <= cnt_d;
            idx_q    <= idx_d;
            cup_q    <= cup_d;
            cdn_q    <= cdn_d;
        end
    end

    for (genvar m = 0; m < 2; m++) begin : g_motor
        for (genvar p = 0; p < 3; p++) begin : g_phase
            logic hi, lo;
            dead_time_phase #(
                .DEAD     (motor_pwm_pkg::DEAD_W)
            ) u_phase (
                .clk_in   (clk_in),
                .rstn_in  (sys_rst_n),
                .tick_in  (tick_q),
                .run_in   (run),
                .level_in (lvl[m][p]),
                .hi_out   (hi),
                .lo_out   (lo)
            );
            if (m == 0) begin : g_m1
                assign motor1_phase_out[p]   = hi;
                assign motor1_phase_n_out[p] = lo;
            end else begin : g_m2
                assign motor2_phase_out[p]   = hi;
                assign motor2_phase_n_out[p] = lo;
            end
        end
    end

    assign pwm_oe_out          = oe_q;
    assign adc_trig_a_out      = ta_q;
    assign adc_trig_b_out      = tb_q;
    assign adc_scan_c_out      = sc_q;
    assign adc0_result_sel_out = sel_q;
    assign conv_status_out_0   = busy_q[0];
    assign conv_status_out_1   = busy_q[1];
    assign conv_frame_sync_0   = fs0_q;
    assign conv_frame_sync_1   = fs1_q;
    assign cycle_toggle_out_1  = tgl_q[0];
    assign cycle_toggle_out_2  = tgl_q[1];
    assign comparator_out      = cmp_q;
    assign reset_cause_out     = cause_q;
    assign running_out         = run;

endmodule // dual_motor_pwm_adc_protect

/* File: core/motor_pwm_pkg.sv */
// Shared constants for the dual motor PWM block: timing, table and field layout.
// Assumes one 25 MHz system clock; the timer tick is derived from it.
package motor_pwm_pkg;

    localparam int unsigned CLK_HZ       = 25000000;
    localparam int unsigned TIMER_HZ     = 8000000;
    localparam int unsigned CARRIER_HZ   = 8000;
    localparam int unsigned DEAD_NS      = 2000;
    localparam int unsigned OFFSET_NS    = 6000;
    localparam int unsigned LVD_MV       = 2510;

    // Fractional tick generator: TIMER_HZ/CLK_HZ reduced to 8/25
    localparam logic [5:0] TICK_STEP     = 6'h08;
    localparam logic [5:0] TICK_MOD      = 6'h19;

    localparam int unsigned CARRIER_CNT  = TIMER_HZ / CARRIER_HZ;
    localparam int unsigned HALF_CNT     = CARRIER_CNT / 2;
    localparam int unsigned DEAD_TICKS   = (TIMER_HZ / 1000) * DEAD_NS / 1000000;
    localparam int unsigned OFFSET_TICKS = (TIMER_HZ / 1000) * OFFSET_NS / 1000000;

    localparam logic [15:0] CARRIER_W    = 16'(CARRIER_CNT);
    localparam logic [15:0] PEAK_W       = 16'(HALF_CNT);
    localparam logic [7:0]  DEAD_W       = 8'(DEAD_TICKS);
    localparam logic [15:0] OFFSET_W     = 16'(OFFSET_TICKS);

    localparam logic [15:0] ADC_T1       = 16'h0258;
    localparam logic [15:0] ADC_T2       = 16'h1194;

    localparam int unsigned TABLE_LEN    = 360;
    localparam logic [8:0]  TABLE_LAST   = 9'h167;
    localparam logic [8:0]  TABLE_HALF   = 9'h0B4;
    localparam logic [8:0]  PHASE_SHIFT  = 9'h078;

    localparam int unsigned RC_PIN_BIT   = 0;
    localparam int unsigned RC_LVD_BIT   = 1;
    localparam logic [1:0]  RC_RESET_VAL = 2'h0;

    typedef enum logic {ST_IDLE, ST_RUN} run_state_t;

endpackage

/* File: sim/dual_motor_pwm_adc_protect_bench.sv */
// Self-checking bench for the dual motor PWM block.
// Assumes design, checker and stage model compiled first.
`timescale 1ns/100ps
module dual_motor_pwm_adc_protect_bench;
    logic       clk_in = 1'b0;
    logic       rstn_in = 1'b0;
    logic       supply_low_in = 1'b0;
    logic       slow = 1'b0;
    logic [4:0] ctl = 5'h03;
    logic [2:0] done, m1p, m1n, m2p, m2n, trga, trgb, scan;
    logic       oe, sel, st0, st1, fs0, tg1, tg2, tg2_q, cmp, run;
    logic [1:0] cause;
    logic [7:0] mon;
    int         cyc = 0;
    int         t_tg2 = 0;
    int         mismatches = 0;
    int         checks_done = 0;
    always #20 clk_in = ~clk_in;
    assign mon = {trgb[0], trga[1], trga[0], m2p[0], m1n[0], m1p[0], tg2, tg1};
    // Second shunt sample moved inside the 1000-tick period
    dual_motor_pwm_adc_protect #(.TRIG_2(16'h0384)) dual_motor_pwm_adc_protect_inst (
        .clk_in, .rstn_in, .start_button_in(ctl[3]), .stop_button_in(ctl[4]),
        .fault_input_0_n_in(ctl[0]), .fault_input_4_n_in(ctl[1]),
        .comparator_in(ctl[2]), .supply_low_in, .adc_done_in(done),
        .motor1_phase_out(m1p), .motor1_phase_n_out(m1n), .motor2_phase_out(m2p),
        .motor2_phase_n_out(m2n), .pwm_oe_out(oe), .adc_trig_a_out(trga),
        .adc_trig_b_out(trgb), .adc_scan_c_out(scan), .adc0_result_sel_out(sel),
        .conv_status_out_0(st0), .conv_status_out_1(st1), .conv_frame_sync_0(fs0),
        .conv_frame_sync_1(), .cycle_toggle_out_1(tg1), .cycle_toggle_out_2(tg2),
        .comparator_out(cmp), .reset_cause_out(cause), .running_out(run));
    motor_stage_model motor_stage_model_inst (
        .clk_in, .rstn_in, .slow_in(slow), .start_in(trga | trgb), .done_out(done));
    always @(negedge clk_in) begin
        cyc <= cyc + 1;
        tg2_q <= tg2;
        if (tg2 !== tg2_q) begin
            t_tg2 <= cyc;
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic near(input string what, input int v, input int e, input int tol);
        check(what, (v - e <= tol && e - v <= tol) ? e : v, e);
    endtask
    task automatic wait_bit(input int k, input logic lvl, output int t);
        int n = 0;
        while (mon[k] !== lvl && n < 4000) begin
            @(negedge clk_in);
            n++;
        end
        check("wait bit", n < 4000, 1'b1);
        t = cyc;
    endtask
    task automatic hit(input int k);
        @(posedge clk_in);
        ctl[k] <= ~ctl[k];
        @(posedge clk_in);
        ctl[k] <= ~ctl[k];
        @(negedge clk_in);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic t_idle;
        repeat (100) @(negedge clk_in);
        check("run", run, 1'b0);
        check("phases", {m1p, m1n, m2p, m2n}, 12'h000);
        check("cause", cause, 2'h1);
        @(posedge clk_in);
        ctl[4:3] <= 2'h3;
        @(posedge clk_in);
        ctl[4:3] <= 2'h0;
        @(negedge clk_in);
        check("run refused", run, 1'b0);
        check("scan idle", scan, 3'h0);
        hit(3);
        check("run", run, 1'b1);
        $display("done idle and start");
    endtask
    task automatic t_shape;
        int t0, t1, tr, tf, tl;
        wait_bit(0, ~tg1, t0);
        wait_bit(0, ~tg1, t1);
        near("period", t1 - t0, 3125, 1);
        check("scan run", scan, 3'h7);
        wait_bit(2, 1'b1, tr);
        wait_bit(2, 1'b0, tf);
        wait_bit(3, 1'b1, tl);
        near("dead", tl - tf, 50, 2);
        near("m1 skew", tr + tf - 2 * t1 - 3125, -98, 10);
        wait_bit(1, ~tg2, t0);
        wait_bit(4, 1'b1, tr);
        wait_bit(4, 1'b0, tf);
        near("m2 skew", tr + tf - 2 * t0 - 3125, 52, 10);
        $display("done shape");
    endtask
    task automatic t_adc;
        int t0, t;
        slow <= 1'b1;
        wait_bit(0, ~tg1, t0);
        wait_bit(7, 1'b1, t);
        near("grp b", t - t0, 1562, 4);
        check("peak trigs", {trga[2], trgb}, 4'hF);
        wait_bit(5, 1'b1, t);
        near("trig 1", t - t0, 1875, 4);
        check("sel 1", sel, 1'b0);
        repeat (20) @(negedge clk_in);
        check("busy slow", st0, 1'b1);
        wait_bit(5, 1'b1, t);
        near("trig 2", t - t0, 2812, 4);
        check("sel 2", sel, 1'b1);
        check("sync 0", fs0, 1'b1);
        slow <= 1'b0;
        wait_bit(6, 1'b1, t);
        check("busy 1", st1, 1'b1);
        repeat (4) @(negedge clk_in);
        near("m2 trough", t - t_tg2, 0, 3);
        $display("done adc");
    endtask
    task automatic t_protect;
        for (int k = 0; k < 3; k++) begin
            hit(k);
            check("oe off", oe, 1'b0);
            check("cmp", cmp, 1'(k == 2));
            repeat (10) @(negedge clk_in);
            check("oe held", oe, 1'b0);
            hit(3);
            @(negedge clk_in);
            check("oe back", oe, 1'b1);
        end
        $display("done protect");
    endtask
    task automatic t_stop_lvd;
        hit(4);
        check("run stop", run, 1'b0);
        repeat (3) @(negedge clk_in);
        check("phases", {m1p, m1n, m2p, m2n}, 12'h000);
        hit(3);
        @(posedge clk_in);
        supply_low_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        supply_low_in <= 1'b0;
        @(negedge clk_in);
        check("lvd run", run, 1'b0);
        check("lvd cause", cause, 2'h2);
        @(posedge clk_in);
        rstn_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rstn_in <= 1'b1;
        @(negedge clk_in);
        check("pin cause", cause, 2'h1);
        $display("done stop and lvd");
    endtask
    initial begin
        repeat (5) @(posedge clk_in);
        rstn_in <= 1'b1;
        t_idle();
        t_shape();
        t_adc();
        t_protect();
        t_stop_lvd();
        report_and_stop();
    end
    // Longest path is about five carrier periods of 3125 cycles
    initial begin
        repeat (60000) @(posedge clk_in);
        mismatches++;
        $display("[FAIL] watchdog expected finish seen timeout");
        report_and_stop();
    end
endmodule // dual_motor_pwm_adc_protect_bench

/* File: sim/dual_motor_pwm_adc_protect_properties.sv */
// Port assertions for the dual motor PWM block.
// Assumes one clock; supply_low_in resets the block like rstn_in.
`timescale 1ns/100ps
module pwm_port_checker (
    input wire logic       clk_in,
    input wire logic       rstn_in,
    input wire logic       start_button_in,
    input wire logic       stop_button_in,
    input wire logic       fault_input_0_n_in,
    input wire logic       fault_input_4_n_in,
    input wire logic       comparator_in,
    input wire logic       supply_low_in,
    input wire logic [2:0] adc_done_in,
    input wire logic [2:0] motor1_phase_out,
    input wire logic [2:0] motor1_phase_n_out,
    input wire logic [2:0] motor2_phase_out,
    input wire logic [2:0] motor2_phase_n_out,
    input wire logic       pwm_oe_out,
    input wire logic [2:0] adc_trig_a_out,
    input wire logic [2:0] adc_trig_b_out,
    input wire logic       conv_status_out_0,
    input wire logic       conv_frame_sync_0,
    input wire logic       conv_frame_sync_1,
    input wire logic       cycle_toggle_out_1,
    input wire logic       running_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in || supply_low_in);
    logic [11:0] gap_q;
    logic        tg_q;
    logic        seen_q;
    wire logic   chg = cycle_toggle_out_1 != tg_q;
    wire logic   trg0 = adc_trig_a_out[0] || adc_trig_b_out[0];
    // Gap is only trusted after one toggle seen in the current run
    always_ff @(posedge clk_in) begin
        tg_q   <= cycle_toggle_out_1;
        gap_q  <= chg ? 12'h001 : gap_q + 12'h001;
        seen_q <= running_out && rstn_in && !supply_low_in && (seen_q || chg);
    end
    property p_no_shoot;
        (motor1_phase_out & motor1_phase_n_out) == 3'h0
            && (motor2_phase_out & motor2_phase_n_out) == 3'h0;
    endproperty
    a_no_shoot: assert property (p_no_shoot) else $error("phase pair both on");
    property p_dead;
        $fell(motor1_phase_out[0]) |-> (motor1_phase_n_out[0] == 1'b0) [*8];
    endproperty
    a_dead: assert property (p_dead) else $error("dead time too short");
    property p_idle;
        !running_out [*3] |-> {motor1_phase_out, motor1_phase_n_out,
            motor2_phase_out, motor2_phase_n_out} == 12'h000;
    endproperty
    a_idle: assert property (p_idle) else $error("phases active while idle");
    property p_start;
        !running_out && start_button_in && !stop_button_in |=> running_out;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");
    property p_stop;
        running_out && stop_button_in |=> !running_out;
    endproperty
    a_stop: assert property (p_stop) else $error("stop not taken");
    property p_fault;
        $fell(fault_input_0_n_in) || $fell(fault_input_4_n_in) || comparator_in
            |=> !pwm_oe_out;
    endproperty
    a_fault: assert property (p_fault) else $error("outputs not disabled");
    property p_hold;
        !pwm_oe_out && !start_button_in |=> !pwm_oe_out;
    endproperty
    a_hold: assert property (p_hold) else $error("disable released early");
    property p_period;
        seen_q && chg |-> gap_q inside {[12'hC34:12'hC36]};
    endproperty
    a_period: assert property (p_period) else $error("carrier toggle period");
    property p_sync1;
        conv_frame_sync_1 == adc_trig_a_out[1];
    endproperty
    a_sync1: assert property (p_sync1) else $error("frame sync 1 mismatch");
    property p_busy;
        trg0 |-> conv_status_out_0;
    endproperty
    a_busy: assert property (p_busy) else $error("status not raised");
    property p_done;
        conv_status_out_0 && adc_done_in[0] && !trg0 |=> !conv_status_out_0 || trg0;
    endproperty
    a_done: assert property (p_done) else $error("status not cleared");
    c_start: cover property (!running_out ##1 running_out);
    c_fault: cover property (pwm_oe_out ##1 !pwm_oe_out);
    c_sync0: cover property (conv_frame_sync_0);
endmodule // pwm_port_checker

bind dual_motor_pwm_adc_protect pwm_port_checker pwm_port_checker_inst (
    .clk_in, .rstn_in, .start_button_in, .stop_button_in, .fault_input_0_n_in,
    .fault_input_4_n_in, .comparator_in, .supply_low_in, .adc_done_in,
    .motor1_phase_out, .motor1_phase_n_out, .motor2_phase_out, .motor2_phase_n_out,
    .pwm_oe_out, .adc_trig_a_out, .adc_trig_b_out, .conv_status_out_0,
    .conv_frame_sync_0, .conv_frame_sync_1, .cycle_toggle_out_1, .running_out);

/* File: sim/motor_stage_model.sv */
// Shunt sense and converter stand-in: each start pulse earns a done pulse.
// Assumes the block's clock and reset; slow_in picks the long conversion.
`timescale 1ns/100ps
module motor_stage_model (
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    input  wire logic       slow_in,
    input  wire logic [2:0] start_in,
    output logic      [2:0] done_out
);
    logic [5:0] left_q [3];
    always_ff @(posedge clk_in) begin
        for (int u = 0; u < 3; u++) begin
            done_out[u] <= rstn_in && left_q[u] == 6'h01;
            if (!rstn_in) begin
                left_q[u] <= 6'h00;
            end else if (start_in[u]) begin
                left_q[u] <= slow_in ? 6'h28 : 6'h03;
            end else if (left_q[u] != 6'h00) begin
                left_q[u] <= left_q[u] - 6'h01;
            end
        end
    end
endmodule // motor_stage_model
